// file: hw/psc_strap_latch.sv
// Strap configuration latch of a 10/100 transceiver
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.svh"

// Contract
// - Sample three address straps at reset release, any value 0 to 7.
// - Address straps at internal pull defaults give address 00001.
// - Upper two address bits are forced to 00.
// - Address 00000 is own unique address only with unique strap high.
// - Unique strap low makes address 0 a broadcast address.
// - Mode straps 000 give normal mode, 110 back-to-back, others reserved.
// - Isolate strap loads control bit 10, high enables isolate.
// - Speed strap loads control bit 13, high means 100 Mbps.
// - Speed strap also sets advertised speed capability bits.
// - Duplex strap loads control bit 8, high means full duplex.
// - Autoneg strap loads control bit 12, high enables autoneg.
// - Test strap sampled low enters gate-chain test mode.
// - Strap pins are inputs during reset and outputs afterwards.
module psc_strap_latch
  import psc_pkg::*;
#(
  parameter int STRAP_W = `PSC_STRAP_COUNT
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [STRAP_W-1:0] strap_pin_in,
  output logic [STRAP_W-1:0] strap_pin_out,
  output logic [STRAP_W-1:0] strap_pin_oe_out,
  input wire logic [STRAP_W-1:0] pin_func_in,
  input wire logic query_valid_in,
  input wire logic [`PSC_ADDR_W-1:0] query_addr_in,
  output logic addr_hit_out,
  output logic bcast_hit_out,
  output logic [`PSC_ADDR_W-1:0] mgmt_addr_strap_out,
  output logic addr_zero_unique_strap_out,
  output var psc_mode_e mode_out,
  output logic mode_reserved_out,
  output logic [15:0] ctrl_seed_out,
  output logic [3:0] adv_speed_out,
  output logic autoneg_enable_strap_out,
  output logic test_mode_out,
  output logic straps_valid_out
);
  logic [STRAP_W-1:0] strap_filt;
  psc_state_e state;
  psc_state_e next_state;
  logic capture;

  logic [2:0] addr_lo;
  logic [2:0] cfg;
  logic iso;
  logic speed;
  logic duplex;
  logic autoneg;
  logic unique_zero;
  logic test_n;
  logic [2:0] next_addr_lo;
  logic [2:0] next_cfg;
  logic next_iso;
  logic next_speed;
  logic next_duplex;
  logic next_autoneg;
  logic next_unique_zero;
  logic next_test_n;

  logic [STRAP_W-1:0] pin_q;
  logic [STRAP_W-1:0] next_pin_q;
  logic [STRAP_W-1:0] oe_q;
  logic [STRAP_W-1:0] next_oe_q;

  logic addr_hit;
  logic bcast_hit;
  logic next_addr_hit;
  logic next_bcast_hit;
  logic [`PSC_ADDR_W-1:0] own_addr;

  // Width check at elaboration
  if (STRAP_W != `PSC_STRAP_COUNT) begin : g_bad_width
    $error("psc_strap_latch: strap vector width must be twelve");
  end

  psc_strap_sync #(
    .W(STRAP_W)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .pin_in(strap_pin_in),
    .filt_out(strap_filt)
  );

  // Sequencer
  always_comb begin
    next_state = state;
    capture = 1'b0;
    unique case (state)
      PSC_ST_HOLD: begin
        capture = 1'b1;
        next_state = PSC_ST_RUN;
      end
      PSC_ST_RUN: begin
        next_state = PSC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= PSC_ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Strap capture
  always_comb begin
    next_addr_lo = addr_lo;
    next_cfg = cfg;
    next_iso = iso;
    next_speed = speed;
    next_duplex = duplex;
    next_autoneg = autoneg;
    next_unique_zero = unique_zero;
    next_test_n = test_n;
    if (capture) begin
      next_addr_lo = strap_filt[`PSC_PIN_ADDR_HI:`PSC_PIN_ADDR_LO];
      next_cfg = strap_filt[`PSC_PIN_CFG_HI:`PSC_PIN_CFG_LO];
      next_iso = strap_filt[`PSC_PIN_ISO];
      next_speed = strap_filt[`PSC_PIN_SPEED];
      next_duplex = strap_filt[`PSC_PIN_DUPLEX];
      next_autoneg = strap_filt[`PSC_PIN_AUTONEG];
      next_unique_zero = strap_filt[`PSC_PIN_UNIQUE];
      next_test_n = strap_filt[`PSC_PIN_TEST_N];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      addr_lo <= `PSC_RST_ADDR;
      cfg <= `PSC_RST_CFG;
      iso <= `PSC_RST_ISO;
      speed <= `PSC_RST_SPEED;
      duplex <= `PSC_RST_DUPLEX;
      autoneg <= `PSC_RST_AUTONEG;
      unique_zero <= `PSC_RST_UNIQUE;
      test_n <= `PSC_RST_TEST_N;
    end else begin
      addr_lo <= next_addr_lo;
      cfg <= next_cfg;
      iso <= next_iso;
      speed <= next_speed;
      duplex <= next_duplex;
      autoneg <= next_autoneg;
      unique_zero <= next_unique_zero;
      test_n <= next_test_n;
    end
  end

  assign own_addr = {`PSC_ADDR_UPPER, addr_lo};

  // Address decode
  always_comb begin
    next_addr_hit = 1'b0;
    next_bcast_hit = 1'b0;
    if (query_valid_in && state == PSC_ST_RUN) begin
      next_addr_hit = (query_addr_in == own_addr) &&
                      ((own_addr != `PSC_ADDR_ZERO) || unique_zero);
      next_bcast_hit = (query_addr_in == `PSC_ADDR_ZERO) && !unique_zero;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      addr_hit <= 1'b0;
      bcast_hit <= 1'b0;
    end else begin
      addr_hit <= next_addr_hit;
      bcast_hit <= next_bcast_hit;
    end
  end

  // Pin drivers
  always_comb begin
    next_pin_q = pin_func_in;
    next_oe_q = oe_q;
    if (state == PSC_ST_RUN) begin
      next_oe_q = {STRAP_W{1'b1}};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_q <= '0;
      oe_q <= '0;
    end else begin
      pin_q <= next_pin_q;
      oe_q <= next_oe_q;
    end
  end

  assign strap_pin_oe_out = rst_in ? '0 : oe_q;
  assign strap_pin_out = pin_q;

  assign mgmt_addr_strap_out = own_addr;
  assign addr_zero_unique_strap_out = unique_zero;
  assign addr_hit_out = addr_hit;
  assign bcast_hit_out = bcast_hit;
  assign straps_valid_out = (state == PSC_ST_RUN);

  always_comb begin
    mode_out = PSC_MODE_RSVD;
    if (cfg == `PSC_CFG_MII) begin
      mode_out = PSC_MODE_MII;
    end else if (cfg == `PSC_CFG_B2B) begin
      mode_out = PSC_MODE_B2B;
    end
  end
  assign mode_reserved_out = (mode_out == PSC_MODE_RSVD);

  // Control register seed
  always_comb begin
    ctrl_seed_out = 16'h0000;
    ctrl_seed_out[`PSC_CTRL_ISO_BIT] = iso;
    ctrl_seed_out[`PSC_CTRL_SPEED_BIT] = speed;
    ctrl_seed_out[`PSC_CTRL_DUPLEX_BIT] = duplex;
    ctrl_seed_out[`PSC_CTRL_AUTONEG_BIT] = autoneg;
  end
  assign autoneg_enable_strap_out = autoneg;

  assign adv_speed_out = speed ? `PSC_ADV_ALL : `PSC_ADV_10_ONLY;
  assign test_mode_out = !test_n;

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_capture;
    state == PSC_ST_HOLD;
  endsequence

  sequence s_settled;
    state == PSC_ST_RUN [*2];
  endsequence

  chk_addr_sample: assert property (
    s_capture |=> mgmt_addr_strap_out[2:0] ==
      $past(strap_filt[`PSC_PIN_ADDR_HI:`PSC_PIN_ADDR_LO]))
    else $error("address straps not latched");

  chk_addr_default: assert property (
    s_capture ##0 (strap_filt[`PSC_PIN_ADDR_HI:`PSC_PIN_ADDR_LO] == `PSC_RST_ADDR)
      |=> mgmt_addr_strap_out == 5'h01)
    else $error("default address not 00001");

  chk_addr_upper: assert property (
    mgmt_addr_strap_out[4:3] == 2'h0)
    else $error("upper address bits not zero");

  chk_zero_unique: assert property (
    query_valid_in && state == PSC_ST_RUN && query_addr_in == 5'h00 && own_addr == 5'h00
      |=> addr_hit_out == $past(unique_zero))
    else $error("address zero unique match wrong");

  chk_zero_bcast: assert property (
    query_valid_in && state == PSC_ST_RUN && query_addr_in == 5'h00
      |=> bcast_hit_out == !addr_zero_unique_strap_out)
    else $error("address zero broadcast match wrong");

  chk_mode_decode: assert property (
    s_capture ##1 1'b1 |-> (mode_out == PSC_MODE_B2B) ==
      ($past(strap_filt[`PSC_PIN_CFG_HI:`PSC_PIN_CFG_LO]) == 3'h6))
    else $error("back-to-back mode decode wrong");

  chk_ctrl_bits: assert property (
    s_capture |=> ctrl_seed_out[10] == $past(strap_filt[`PSC_PIN_ISO]) &&
      ctrl_seed_out[13] == $past(strap_filt[`PSC_PIN_SPEED]) &&
      ctrl_seed_out[8] == $past(strap_filt[`PSC_PIN_DUPLEX]) &&
      ctrl_seed_out[12] == $past(strap_filt[`PSC_PIN_AUTONEG]))
    else $error("control seed bits not latched");

  chk_adv_speed: assert property (
    adv_speed_out[3:2] == {2{ctrl_seed_out[13]}} && adv_speed_out[1:0] == 2'h3)
    else $error("advertised speed does not follow speed strap");

  chk_test_mode: assert property (
    s_capture |=> test_mode_out == !$past(strap_filt[`PSC_PIN_TEST_N]))
    else $error("test mode strap not honoured");

  chk_pin_enable: assert property (
    s_capture |-> strap_pin_oe_out == '0 ##1 strap_pin_oe_out == '0
      ##1 strap_pin_oe_out == {STRAP_W{1'b1}})
    else $error("strap pin enable timing wrong");

  chk_hold_stable: assert property (
    s_settled |-> $stable(mgmt_addr_strap_out) && $stable(ctrl_seed_out) &&
      $stable(mode_out) && $stable(test_mode_out) && $stable(addr_zero_unique_strap_out))
    else $error("latched straps changed after capture");
endmodule // psc_strap_latch
`default_nettype wire

// file: hw/psc_consts.svh
// Constant macros for the strap configuration latch
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// Strap pin vector layout
`define PSC_STRAP_COUNT 12
`define PSC_PIN_ADDR_LO 0
`define PSC_PIN_ADDR_HI 2
`define PSC_PIN_CFG_LO 3
`define PSC_PIN_CFG_HI 5
`define PSC_PIN_ISO 6
`define PSC_PIN_SPEED 7
`define PSC_PIN_DUPLEX 8
`define PSC_PIN_AUTONEG 9
`define PSC_PIN_UNIQUE 10
`define PSC_PIN_TEST_N 11

// Pad levels with only the internal pulls acting
`define PSC_PULL_DEFAULTS 12'hb81

// Basic control register field positions
`define PSC_CTRL_DUPLEX_BIT 8
`define PSC_CTRL_ISO_BIT 10
`define PSC_CTRL_AUTONEG_BIT 12
`define PSC_CTRL_SPEED_BIT 13

// Advertisement speed capability field, 4 bits wide, {100fd,100hd,10fd,10hd}
`define PSC_ADV_ALL 4'hf
`define PSC_ADV_10_ONLY 4'h3

// Reset values of the latched straps
`define PSC_RST_ADDR 3'h1
`define PSC_RST_CFG 3'h0
`define PSC_RST_ISO 1'b0
`define PSC_RST_SPEED 1'b1
`define PSC_RST_DUPLEX 1'b1
`define PSC_RST_AUTONEG 1'b1
`define PSC_RST_UNIQUE 1'b0
`define PSC_RST_TEST_N 1'b1

// Interface mode codes
`define PSC_CFG_MII 3'h0
`define PSC_CFG_B2B 3'h6

// Width of the management address
`define PSC_ADDR_W 5
`define PSC_ADDR_UPPER 2'h0
`define PSC_ADDR_ZERO 5'h00

`endif

// file: hw/psc_pkg.sv
// Types for the strap configuration latch
`default_nettype none
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_MODE_MII,
    PSC_MODE_B2B,
    PSC_MODE_RSVD
  } psc_mode_e;

  typedef enum logic {
    PSC_ST_HOLD,
    PSC_ST_RUN
  } psc_state_e;
endpackage
`default_nettype wire

// file: hw/psc_strap_sync.sv
// Three-stage synchroniser with agreement filter for strap pins
`timescale 1ns/1ps
`default_nettype none
module psc_strap_sync #(
  parameter int W = 12
) (
  input wire logic core_clk_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] filt_out
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] filt;
  logic [W-1:0] next_filt;

  // Width check at elaboration
  if (W < 1) begin : g_bad_width
    $error("psc_strap_sync: width must be at least one");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Change counts once stages two and three agree
      always_comb begin
        next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    s1 <= pin_in;
    s2 <= s1;
    s3 <= s2;
    filt <= next_filt;
  end

  assign filt_out = filt;
endmodule // psc_strap_sync
`default_nettype wire

// file: dv/psc_board_straps.sv
// Board strap resistor model for the strap latch
`timescale 1ns/1ps
`default_nettype none
module psc_board_straps #(
  parameter int W = 12
) (
  input wire logic [W-1:0] pull_in,
  input wire logic [W-1:0] dev_out_in,
  input wire logic [W-1:0] dev_oe_in,
  output logic [W-1:0] pad_out
);
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pad_out[i] = dev_oe_in[i] ? dev_out_in[i] : pull_in[i];
    end
  end
endmodule // psc_board_straps
`default_nettype wire

// file: dv/psc_strap_latch_bench.sv
// Self-checking bench for the strap latch
`timescale 1ns/1ps
`default_nettype none
`include "psc_consts.svh"
module psc_strap_latch_bench import psc_pkg::*;;
  logic core_clk_in;
  logic rst_in;
  logic [11:0] pull;
  logic [11:0] pad;
  logic [11:0] pin_out;
  logic [11:0] oe;
  logic [11:0] pin_func;
  logic qv;
  logic [4:0] qa;
  logic hit;
  logic bcast;
  logic [4:0] addr;
  logic uniq;
  psc_mode_e mode;
  logic rsvd;
  logic [15:0] ctrl;
  logic [3:0] adv;
  logic an;
  logic tmode;
  logic valid;
  int mismatches;
  int samples_checked;
  int cycles;

  psc_board_straps i_psc_board_straps (.pull_in(pull), .dev_out_in(pin_out),
    .dev_oe_in(oe), .pad_out(pad));

  psc_strap_latch i_psc_strap_latch (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .strap_pin_in(pad), .strap_pin_out(pin_out), .strap_pin_oe_out(oe),
    .pin_func_in(pin_func), .query_valid_in(qv), .query_addr_in(qa),
    .addr_hit_out(hit), .bcast_hit_out(bcast), .mgmt_addr_strap_out(addr),
    .addr_zero_unique_strap_out(uniq), .mode_out(mode), .mode_reserved_out(rsvd),
    .ctrl_seed_out(ctrl), .adv_speed_out(adv), .autoneg_enable_strap_out(an),
    .test_mode_out(tmode), .straps_valid_out(valid));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic restart(input logic [11:0] cfg);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    pull <= cfg;
    repeat (9) @(posedge core_clk_in);
    qv <= 1'b1;
    qa <= {2'b00, cfg[2:0]};
    @(posedge core_clk_in);
    qv <= 1'b0;
    #1 check(16'({hit, bcast}), 16'h0);
    check(16'(oe), 16'h0);
    check(16'(valid), 16'h0);
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    #1 check(16'(oe), 16'h0);
    check(16'(valid), 16'h1);
    @(posedge core_clk_in);
    #1 check(16'(oe), 16'hfff);
  endtask

  task automatic query(input logic [4:0] a, input logic [11:0] cfg);
    logic [4:0] own;
    own = {2'b00, cfg[2:0]};
    @(posedge core_clk_in);
    qv <= 1'b1;
    qa <= a;
    @(posedge core_clk_in);
    qv <= 1'b0;
    #1 check(16'(hit), 16'((a == own) && (own != 5'h00 || cfg[10])));
    check(16'(bcast), 16'((a == 5'h00) && !cfg[10]));
  endtask

  task automatic verify(input logic [11:0] cfg);
    psc_mode_e m;
    logic [15:0] c;
    m = (cfg[5:3] == `PSC_CFG_MII) ? PSC_MODE_MII :
        (cfg[5:3] == `PSC_CFG_B2B) ? PSC_MODE_B2B : PSC_MODE_RSVD;
    c = 16'h0000;
    c[`PSC_CTRL_ISO_BIT] = cfg[6];
    c[`PSC_CTRL_SPEED_BIT] = cfg[7];
    c[`PSC_CTRL_DUPLEX_BIT] = cfg[8];
    c[`PSC_CTRL_AUTONEG_BIT] = cfg[9];
    restart(cfg);
    check(16'(addr), 16'({2'b00, cfg[2:0]}));
    check(16'(mode), 16'(m));
    check(16'(rsvd), 16'(cfg[5:3] != 3'h0 && cfg[5:3] != 3'h6));
    check(ctrl, c);
    check(16'(adv), cfg[7] ? 16'hf : 16'h3);
    check(16'(an), 16'(cfg[9]));
    check(16'(uniq), 16'(cfg[10]));
    check(16'(tmode), 16'(!cfg[11]));
    query({2'b00, cfg[2:0]}, cfg);
    query(5'h00, cfg);
    query({2'b00, cfg[2:0] ^ 3'h1}, cfg);
    query(5'h09, cfg);
    @(posedge core_clk_in);
    pin_func <= ~cfg;
    repeat (6) @(posedge core_clk_in);
    #1 check(16'(pin_out), {4'h0, ~cfg});
    check(16'(addr), 16'({2'b00, cfg[2:0]}));
    check(ctrl, c);
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    rst_in = 1'b1;
    pull = `PSC_PULL_DEFAULTS;
    pin_func = 12'h000;
    qv = 1'b0;
    qa = 5'h00;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    verify(`PSC_PULL_DEFAULTS);
    check(16'(addr), 16'h1);
    verify(12'h7f6);
    verify(12'h800);
    verify(12'hc00);
    for (int k = 0; k < 8; k++) begin
      verify(12'hb80 | 12'(k) | (12'(k) << 3));
    end
    summarize();
  end
endmodule // psc_strap_latch_bench
`default_nettype wire
